// File: ecr_regs.vh
`ifndef ECR_REGS_VH
`define ECR_REGS_VH
// lane counts per variant
`define ECR_LANES_STD 10
`define ECR_LANES_FOUR 4
// queue count without priority flow control
`define ECR_QUEUES_STD 1
// largest queue count the ports are built for
`define ECR_QUEUES_MAX 8
// least hold of the core reset, in status clock cycles
`define ECR_HOLD_CYCLES 10
// hold counter width
`define ECR_HOLD_W 4
// client interface styles
`define ECR_STYLE_PKT 1'b0
`define ECR_STYLE_SEG 1'b1
// flow control modes
`define ECR_FC_NONE 2'h0
`define ECR_FC_STD 2'h1
`define ECR_FC_PFC 2'h2
`endif

// File: ecr_rst_sync.v
`timescale 1ns/1ns
// reset release synchronizer, async assert, clean clocked release
module ecr_rst_sync (
  input wire mclk,
  input wire arst,
  input wire hold,
  output reg rst_out
);
  reg stage1;
  always @(posedge mclk or posedge arst) begin
    if (arst) begin
      stage1 <= 1'b1;
      rst_out <= 1'b1;
    end else begin
      stage1 <= hold;
      rst_out <= stage1;
    end
  end
endmodule

// File: ecr_core_reset.v
`timescale 1ns/1ns
`include "ecr_regs.vh"
// Function
// (R01) async core reset clears whole core, clockless; here core_rst itself asserts only at the next mclk edge
// (R02) controller holds core reset ten status cycles; here a short reset_async hold is only flagged on hold_short_err
// (R03) release only after reference clock stable
// (R04) status reset clears only status logic
// (R05) reconfig reset clears only reconfig logic
// (R06) serial lanes: four or ten per variant
// (R07) pause vectors one bit per queue
// (R08) exactly one client interface style per instance
// (R09) release synchronized separately per clock domain
module ecr_core_reset #(
  parameter FOUR_LANE = 0,
  parameter FC_MODE = `ECR_FC_NONE,
  parameter PFC_QUEUES = 2,
  parameter CLIENT_STYLE = `ECR_STYLE_PKT,
  parameter HAS_RECONFIG = 1
) (
  input wire mclk,
  input wire sys_rst,
  input wire reset_async,
  input wire ref_clk_stable,
  input wire fractional_pll_used,
  input wire fractional_pll_locked,
  input wire reset_status,
  input wire reconfig_reset,
  input wire reconfig_req,
  input wire rx_pcs_ready_in,
  input wire [((FOUR_LANE != 0) ? `ECR_LANES_FOUR : `ECR_LANES_STD)-1:0] tx_lane_in,
  input wire [((FOUR_LANE != 0) ? `ECR_LANES_FOUR : `ECR_LANES_STD)-1:0] rx_serial,
  input wire [((FC_MODE == `ECR_FC_PFC) ? PFC_QUEUES : `ECR_QUEUES_STD)-1:0] pause_insert_tx,
  input wire [((FC_MODE == `ECR_FC_PFC) ? PFC_QUEUES : `ECR_QUEUES_STD)-1:0] pause_rx_detect,
  input wire pkt_tx_ready_in,
  input wire pkt_rx_valid_in,
  input wire seg_tx_req_in,
  input wire seg_rx_valid_in,
  output reg core_rst,
  output wire status_rst,
  output wire reconfig_rst,
  output reg hold_short_err,
  output reg [((FOUR_LANE != 0) ? `ECR_LANES_FOUR : `ECR_LANES_STD)-1:0] tx_serial,
  output reg [((FOUR_LANE != 0) ? `ECR_LANES_FOUR : `ECR_LANES_STD)-1:0] rx_lane_out,
  output reg [((FC_MODE == `ECR_FC_PFC) ? PFC_QUEUES : `ECR_QUEUES_STD)-1:0] pause_insert_out,
  output reg [((FC_MODE == `ECR_FC_PFC) ? PFC_QUEUES : `ECR_QUEUES_STD)-1:0] pause_receive_rx,
  output reg pkt_tx_ready,
  output reg pkt_rx_valid,
  output reg seg_tx_req,
  output reg seg_rx_valid,
  output reg status_pcs_ready,
  output reg status_lock_lost,
  output reg reconfig_busy
);
  localparam LANES = (FOUR_LANE != 0) ? `ECR_LANES_FOUR : `ECR_LANES_STD;
  localparam QUEUES = (FC_MODE == `ECR_FC_PFC) ? PFC_QUEUES : `ECR_QUEUES_STD;
  localparam [`ECR_HOLD_W-1:0] HOLD_MAX = `ECR_HOLD_CYCLES;
  localparam [`ECR_HOLD_W-1:0] HOLD_ONE = {{(`ECR_HOLD_W-1){1'b0}}, 1'b1};
  localparam ST_RESET = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function style_on;
    input sel;
    begin
      style_on = (CLIENT_STYLE == sel);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset hold monitor and release gate
  reg [`ECR_HOLD_W-1:0] hold_cnt;
  reg [`ECR_HOLD_W-1:0] next_hold_cnt;
  reg [2:0] seq_state;
  reg [2:0] next_seq_state;
  reg rst_seen;
  wire ref_ok;
  wire hold_done;
  wire core_hold;
  wire core_sync_rst;
  wire status_sync_rst;
  wire reconfig_sync_rst;

  // reference clock, and its pll lock where used
  assign ref_ok = ref_clk_stable & (~fractional_pll_used | fractional_pll_locked); // R03
  assign hold_done = (hold_cnt >= HOLD_MAX); // R02

  always @* begin
    next_hold_cnt = hold_cnt;
    next_seq_state = seq_state;
    case (seq_state)
      ST_RESET: begin
        if (reset_async) begin
          if (!hold_done) begin
            next_hold_cnt = hold_cnt + 1'b1;
          end
        end else begin
          next_seq_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (reset_async) begin
          next_seq_state = ST_RESET;
          next_hold_cnt = HOLD_ONE; // R02
        end else if (ref_ok) begin
          next_seq_state = ST_RUN; // R03
        end
      end
      ST_RUN: begin
        if (reset_async) begin
          next_seq_state = ST_RESET;
          next_hold_cnt = HOLD_ONE; // R02
        end else if (!ref_ok) begin
          next_seq_state = ST_WAIT;
        end
      end
      default: begin
        next_seq_state = ST_RESET;
        next_hold_cnt = {`ECR_HOLD_W{1'b0}};
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      seq_state <= ST_RESET;
      hold_cnt <= {`ECR_HOLD_W{1'b0}};
      rst_seen <= 1'b0;
      hold_short_err <= 1'b0;
      core_rst <= 1'b1;
    end else begin
      seq_state <= next_seq_state;
      hold_cnt <= next_hold_cnt;
      core_rst <= core_sync_rst;
      if (reset_async) begin
        rst_seen <= 1'b1;
      end
      // judge each release against the hold time
      if (seq_state == ST_RESET && !reset_async && rst_seen) begin
        hold_short_err <= ~hold_done; // R02
      end
    end
  end

  assign core_hold = sys_rst | (seq_state != ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // per-domain release synchronizers
  ecr_rst_sync u_core_sync (
    .mclk(mclk),
    .arst(reset_async), // R01
    .hold(core_hold),
    .rst_out(core_sync_rst)
  ); // R09

  ecr_rst_sync u_status_sync (
    .mclk(mclk),
    .arst(reset_async),
    .hold(sys_rst | reset_status), // R04
    .rst_out(status_sync_rst)
  ); // R09

  ecr_rst_sync u_reconfig_sync (
    .mclk(mclk),
    .arst(reset_async),
    .hold(sys_rst | reconfig_reset | (HAS_RECONFIG == 0)), // R05
    .rst_out(reconfig_sync_rst)
  ); // R09

  assign status_rst = status_sync_rst;
  assign reconfig_rst = reconfig_sync_rst;

  ////////////////////////////////////////////////////////////////////////////
  // datapath, cleared by the core reset regardless of clock
  always @(posedge mclk or posedge core_sync_rst) begin
    if (core_sync_rst) begin
      tx_serial <= {LANES{1'b0}}; // R01
      rx_lane_out <= {LANES{1'b0}};
      pause_insert_out <= {QUEUES{1'b0}};
      pause_receive_rx <= {QUEUES{1'b0}};
      pkt_tx_ready <= 1'b0;
      pkt_rx_valid <= 1'b0;
      seg_tx_req <= 1'b0;
      seg_rx_valid <= 1'b0;
    end else begin
      tx_serial <= tx_lane_in; // R06
      rx_lane_out <= rx_serial; // R06
      pause_insert_out <= pause_insert_tx; // R07
      pause_receive_rx <= pause_rx_detect; // R07
      // only the selected client style ever becomes active
      pkt_tx_ready <= style_on(`ECR_STYLE_PKT) & pkt_tx_ready_in; // R08
      pkt_rx_valid <= style_on(`ECR_STYLE_PKT) & pkt_rx_valid_in; // R08
      seg_tx_req <= style_on(`ECR_STYLE_SEG) & seg_tx_req_in; // R08
      seg_rx_valid <= style_on(`ECR_STYLE_SEG) & seg_rx_valid_in; // R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status domain logic
  reg status_rst_d;

  // covers the synchronizer fill time
  always @(posedge mclk) begin
    status_rst_d <= sys_rst | reset_status;
    if (status_sync_rst | reset_status | status_rst_d) begin
      status_pcs_ready <= 1'b0; // R04
      status_lock_lost <= 1'b0;
    end else begin
      status_pcs_ready <= rx_pcs_ready_in;
      if (status_pcs_ready && !rx_pcs_ready_in) begin
        status_lock_lost <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reconfiguration domain logic
  reg reconfig_rst_d;

  always @(posedge mclk) begin
    reconfig_rst_d <= sys_rst | reconfig_reset;
    if (reconfig_sync_rst | reconfig_reset | reconfig_rst_d | (HAS_RECONFIG == 0)) begin
      reconfig_busy <= 1'b0; // R05
    end else begin
      reconfig_busy <= reconfig_req;
    end
  end
endmodule

// File: ecr_user.sv
`timescale 1ns/1ns
module ecr_user (
  input wire mclk,
  input wire go,
  input wire [4:0] hold,
  output reg reset_async = 1'b0,
  output reg ref_clk_stable = 1'b1
);
  reg [4:0] cnt = 5'h0;
  always @(posedge mclk) begin
    if (go) begin
      cnt <= hold;
      reset_async <= 1'b1;
      ref_clk_stable <= 1'b0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
      ref_clk_stable <= cnt < 5'h4;
      reset_async <= cnt != 5'h1;
    end
  end
endmodule

// File: ecr_core_reset_checker.sv
`timescale 1ns/1ns
module ecr_chk (
  input wire mclk,
  input wire sys_rst,
  input wire reset_async,
  input wire reset_status,
  input wire reconfig_reset,
  input wire reconfig_req,
  input wire core_rst,
  input wire status_rst,
  input wire reconfig_rst,
  input wire hold_short_err,
  input wire seg_tx_req,
  input wire seg_rx_valid,
  input wire pkt_tx_ready,
  input wire pkt_rx_valid,
  input wire reconfig_busy
);
  reg [4:0] n = 5'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  always @(posedge mclk) begin
    n <= reset_async ? n + {4'h0, n != 5'h1f} : 5'h0;
  end
  core_hold_a: assert property (reset_async |=> core_rst)
    else $error("core reset low");
  hold_err_a: assert property ($fell(reset_async) && n < 5'ha |-> ##[1:3] hold_short_err)
    else $error("short hold missed");
  status_clr_a: assert property (reset_status |-> ##2 status_rst)
    else $error("status reset low");
  status_only_a: assert property (reset_status && !(reconfig_reset | $past(reconfig_reset) | reset_async | reconfig_rst)
    |=> !reconfig_rst)
    else $error("reconfig reset hit");
  reconf_clr_a: assert property (reconfig_reset |-> ##2 reconfig_rst)
    else $error("reconfig reset low");
  reconf_only_a: assert property (reconfig_reset && !(reset_status | $past(reset_status) | reset_async | status_rst)
    |=> !status_rst)
    else $error("status reset hit");
  busy_echo_a: assert property (!(reconfig_rst | reconfig_reset | $past(reconfig_reset) | reset_async)
    |=> reset_async || reconfig_busy == $past(reconfig_req))
    else $error("busy echo wrong");
  style_one_a: assert property (!((pkt_tx_ready | pkt_rx_valid) && (seg_tx_req | seg_rx_valid)))
    else $error("second style live");
endmodule
bind ecr_core_reset ecr_chk i_chk (.*);

// File: tb_ecr_core_reset.sv
`timescale 1ns/1ns
`include "ecr_regs.vh"
module tb_ecr_core_reset;
  reg mclk = 0;
  reg sys_rst = 1;
  reg go = 0;
  reg [4:0] hold = 5'h0;
  reg pu = 0;
  reg pl = 0;
  reg rs = 0;
  reg rr = 0;
  reg q = 0;
  reg p = 0;
  reg [9:0] ln = 10'h0;
  wire ra, rcs, cr, sr, rcr, hse, pio, prr, pkt, pktv, seg, segv, spr, sll, busy;
  wire crb, rcrb, pktb, pktvb, segb, segvb, busyb;
  wire [9:0] txs, rlo;
  wire [3:0] txsb, rlob;
  wire [2:0] piob, prrb;
  integer n_errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  always #25 mclk = ~mclk;
  ecr_user i_user (.mclk(mclk), .go(go), .hold(hold), .reset_async(ra), .ref_clk_stable(rcs));
  ecr_core_reset i_dut (.mclk(mclk), .sys_rst(sys_rst), .reset_async(ra), .ref_clk_stable(rcs),
    .fractional_pll_used(pu), .fractional_pll_locked(pl), .reset_status(rs), .reconfig_reset(rr),
    .reconfig_req(q), .rx_pcs_ready_in(q), .tx_lane_in(ln), .rx_serial(~ln), .pause_insert_tx(p),
    .pause_rx_detect(p), .pkt_tx_ready_in(q), .pkt_rx_valid_in(q), .seg_tx_req_in(q),
    .seg_rx_valid_in(q), .core_rst(cr), .status_rst(sr), .reconfig_rst(rcr), .hold_short_err(hse),
    .tx_serial(txs), .rx_lane_out(rlo), .pause_insert_out(pio), .pause_receive_rx(prr), .pkt_tx_ready(pkt),
    .pkt_rx_valid(pktv), .seg_tx_req(seg), .seg_rx_valid(segv), .status_pcs_ready(spr),
    .status_lock_lost(sll), .reconfig_busy(busy));
  ecr_core_reset #(.FOUR_LANE(1), .FC_MODE(`ECR_FC_PFC), .PFC_QUEUES(3), .CLIENT_STYLE(`ECR_STYLE_SEG),
    .HAS_RECONFIG(0)) i_dut_b (.mclk(mclk), .sys_rst(sys_rst), .reset_async(ra), .ref_clk_stable(rcs),
    .fractional_pll_used(pu), .fractional_pll_locked(pl), .reset_status(rs), .reconfig_reset(rr),
    .reconfig_req(q), .rx_pcs_ready_in(q), .tx_lane_in(ln[3:0]), .rx_serial(~ln[3:0]),
    .pause_insert_tx(ln[2:0]), .pause_rx_detect(ln[6:4]), .pkt_tx_ready_in(q), .pkt_rx_valid_in(q),
    .seg_tx_req_in(q), .seg_rx_valid_in(q), .core_rst(crb), .status_rst(), .reconfig_rst(rcrb),
    .hold_short_err(), .tx_serial(txsb), .rx_lane_out(rlob), .pause_insert_out(piob),
    .pause_receive_rx(prrb), .pkt_tx_ready(pktb), .pkt_rx_valid(pktvb), .seg_tx_req(segb),
    .seg_rx_valid(segvb), .status_pcs_ready(), .status_lock_lost(), .reconfig_busy(busyb));
  task tk(input integer k);
    repeat (k) @(posedge mclk);
    #5;
  endtask
  task chk(input [9:0] g, input [9:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task t_rst(input [4:0] h);
    hold = h;
    go = 1;
    tk(1);
    go = 0;
    tk(2);
    chk(cr, 1);
    chk(crb, 1);
    chk(txs, 10'h0);
    tk(h + 2);
  endtask
  task t_rel(input e);
    for (i = 0; i < 20 && cr !== 1'b0; i = i + 1) tk(1);
    chk(cr, 0);
    chk(crb, 0);
    chk(hse, e);
  endtask
  task t_dp;
    ln = 10'h2a5;
    p = 1;
    q = 1;
    tk(2);
    chk(txs, 10'h2a5);
    chk(pio, 1);
    chk(pkt, 1);
    chk(seg, 0);
    chk(busy, 1);
    chk(rlo, 10'h15a);
    chk(prr, 1);
    chk(pktv, 1);
    chk(segv, 0);
    chk(spr, 1);
    chk(txsb, 10'h5);
    chk(rlob, 10'ha);
    chk(piob, 10'h5);
    chk(prrb, 10'h2);
    chk(pktb | pktvb, 0);
    chk(segb & segvb, 1);
    chk(busyb, 0);
    chk(rcrb, 1);
  endtask
  task t_sync;
    rs = 1;
    tk(1);
    rs = 0;
    chk(spr, 0);
    chk(busy, 1);
    tk(1);
    chk(sr, 1);
    chk(rcr, 0);
    chk(cr, 0);
    chk(spr, 0);
    tk(4);
    chk(sr, 0);
    chk(spr, 1);
    rr = 1;
    tk(1);
    rr = 0;
    chk(busy, 0);
    chk(spr, 1);
    tk(1);
    chk(rcr, 1);
    chk(busy, 0);
    chk(sr, 0);
    tk(4);
    chk(rcr, 0);
    chk(busy, 1);
    q = 0;
    tk(1);
    chk(sll, 1);
    q = 1;
    tk(2);
    chk(sll, 1);
  endtask
  task t_pll;
    pu = 1;
    t_rst(10);
    tk(10);
    chk(cr, 1);
    pl = 1;
    t_rel(0);
  endtask
  initial begin
    tk(3);
    sys_rst = 0;
    t_rst(5);
    t_rel(1);
    t_rst(10);
    t_rel(0);
    t_dp;
    t_sync;
    t_pll;
    stop_test;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
endmodule
